// ==== core/led_i2c_target.sv ====
`timescale 1ns/1ps
module led_i2c_target
   import led_i2c_pkg::*;
(
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST,
   // serial link
   i2c_link_if.dev_mp LINK,
   // strap and status
   input wire strap_e I_STRAP,
   input wire logic [7:0] I_IRQ_STATUS,
   // page register read port
   output logic [7:0] O_RD_ADDR,
   input wire logic [7:0] I_RD_DATA,
   // page register write port
   output logic O_WR_STB,
   output logic [7:0] O_WR_PAGE,
   output logic [7:0] O_WR_ADDR,
   output logic [7:0] O_WR_DATA,
   // configuration
   output logic [7:0] O_PAGE,
   output logic [7:0] O_IRQ_MASK
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [4:0] {
      D_IDLE = 5'b00001,
      D_RX = 5'b00010,
      D_ACK = 5'b00100,
      D_TX = 5'b01000,
      D_TXACK = 5'b10000
   } dev_st_e;
   typedef enum logic [1:0] {
      K_ADDR = 2'h0,
      K_REG = 2'h1,
      K_DATA = 2'h2
   } kind_e;
   typedef struct packed {
      dev_st_e st;
      kind_e kind;
      logic scl_q;
      logic sda_q;
      logic strap_ok;
      logic rw;
      logic oe;
      logic wr_stb;
      logic [3:0] addr_lo;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic [7:0] page;
      logic [7:0] key;
      logic [7:0] mask;
      logic [7:0] wr_page;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
   } dev_s;
   localparam dev_s DEV_RST = '{st: D_IDLE, kind: K_ADDR, scl_q: 1'b1,
      sda_q: 1'b1, strap_ok: 1'b0, rw: 1'b0, oe: 1'b0, wr_stb: 1'b0,
      addr_lo: 4'h0, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
      page: PAGE_RESET, key: KEY_RESET, mask: MASK_RESET,
      wr_page: 8'h00, wr_addr: 8'h00, wr_data: 8'h00};
   dev_s s_q;
   dev_s s_d;
   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic [7:0] rd_c;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // strap level to the four low address bits
   function automatic logic [3:0] strap_bits(input strap_e t);
      case (t)
         TIE_VCC: strap_bits = STRAP_BITS_VCC;
         TIE_SCL: strap_bits = STRAP_BITS_SCL;
         TIE_SDA: strap_bits = STRAP_BITS_SDA;
         default: strap_bits = STRAP_BITS_GND;
      endcase
   endfunction
   // read value; unreadable registers return zero
   function automatic logic [7:0] rd_value(input logic [7:0] p,
      input logic [7:0] pg, input logic [7:0] k, input logic [7:0] st,
      input logic [7:0] ext);
      rd_value = 8'h00;
      if (p == REG_UNLOCK_KEY) begin
         rd_value = k;
      end else if (p == REG_IRQ_STATUS) begin
         rd_value = st;
      end else if (pg == LED_CONTROL_PAGE &&
                   ((p >= STAT_A_LO && p <= STAT_A_HI) ||
                    (p >= STAT_B_LO && p <= STAT_B_HI))) begin
         rd_value = ext;
      end else if (pg == FUNCTION_PAGE && p == FUNC_READ_REG) begin
         rd_value = ext;
      end
   endfunction
   // ----------------------------------------
   // bus conditions
   // ----------------------------------------
   // inputs are synchronous, so one sample is enough for edges
   assign start_c = s_q.scl_q & LINK.scl & s_q.sda_q & ~LINK.sda;
   assign stop_c = s_q.scl_q & LINK.scl & ~s_q.sda_q & LINK.sda;
   assign rise_c = ~s_q.scl_q & LINK.scl;
   assign fall_c = s_q.scl_q & ~LINK.scl;
   assign rd_c = rd_value(s_q.ptr, s_q.page, s_q.key, I_IRQ_STATUS,
                          I_RD_DATA);
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.wr_stb = 1'b0;
      s_d.scl_q = LINK.scl;
      s_d.sda_q = LINK.sda;
      // strap caught on the first clock after reset release
      if (!s_q.strap_ok) begin
         s_d.strap_ok = 1'b1;
         s_d.addr_lo = strap_bits(I_STRAP);
      end
      if (start_c) begin
         // also a repeated start in the middle of a transfer
         s_d.st = D_RX;
         s_d.kind = K_ADDR;
         s_d.cnt = 4'h0;
         s_d.oe = 1'b0;
      end else if (stop_c) begin
         s_d.st = D_IDLE;
         s_d.oe = 1'b0;
      end else begin
         case (s_q.st)
            D_RX: begin
               if (rise_c && s_q.cnt != 4'h8) begin
                  s_d.sh = {s_q.sh[6:0], LINK.sda};
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (fall_c && s_q.cnt == 4'h8) begin
                  s_d.cnt = 4'h0;
                  s_d.oe = 1'b1;
                  s_d.st = D_ACK;
                  case (s_q.kind)
                     K_ADDR: begin
                        if (s_q.sh[7:1] == {ADDR_HIGH, s_q.addr_lo}) begin
                           s_d.rw = s_q.sh[0];
                        end else begin
                           s_d.oe = 1'b0;
                           s_d.st = D_IDLE;
                        end
                     end
                     K_REG: s_d.ptr = s_q.sh;
                     default: begin
                        s_d.ptr = s_q.ptr + 8'h01;
                        case (s_q.ptr)
                           REG_PAGE_SELECT: begin
                              // locked unless the key was armed
                              if (s_q.key == UNLOCK_VALUE) begin
                                 s_d.page = s_q.sh;
                                 s_d.key = KEY_RESET;
                              end
                           end
                           REG_UNLOCK_KEY: s_d.key = s_q.sh;
                           REG_IRQ_MASK: s_d.mask = s_q.sh;
                           REG_IRQ_STATUS: ;
                           default: begin
                              s_d.wr_stb = 1'b1;
                              s_d.wr_page = s_q.page;
                              s_d.wr_addr = s_q.ptr;
                              s_d.wr_data = s_q.sh;
                           end
                        endcase
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (fall_c) begin
                  if (s_q.kind == K_ADDR && s_q.rw) begin
                     s_d.st = D_TX;
                     s_d.sh = rd_c;
                     s_d.oe = ~rd_c[7];
                  end else begin
                     s_d.st = D_RX;
                     s_d.oe = 1'b0;
                     s_d.kind = (s_q.kind == K_ADDR) ? K_REG : K_DATA;
                  end
               end
            end
            D_TX: begin
               // data changes only while the clock is low
               if (fall_c) begin
                  if (s_q.cnt == 4'h7) begin
                     s_d.oe = 1'b0;
                     s_d.cnt = 4'h0;
                     s_d.st = D_TXACK;
                  end else begin
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                     s_d.oe = ~s_q.sh[6];
                     s_d.cnt = s_q.cnt + 4'h1;
                  end
               end
            end
            D_TXACK: begin
               // pointer moves on the master's ack so the page
               // port shows the next address before the fall
               if (rise_c) begin
                  if (LINK.sda) begin
                     s_d.st = D_IDLE;
                  end else begin
                     s_d.cnt = 4'h8;
                     s_d.ptr = s_q.ptr + 8'h01;
                  end
               end else if (fall_c && s_q.cnt == 4'h8) begin
                  s_d.cnt = 4'h0;
                  s_d.st = D_TX;
                  s_d.sh = rd_c;
                  s_d.oe = ~rd_c[7];
               end
            end
            default: s_d.st = D_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // registers and outputs
   // ----------------------------------------
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         s_q <= DEV_RST;
      end else begin
         s_q <= s_d;
      end
   end
   // driver only ever pulls low
   assign LINK.dev_sda_out = 1'b0;
   assign LINK.dev_sda_oe = s_q.oe;
   assign O_RD_ADDR = s_q.ptr;
   assign O_WR_STB = s_q.wr_stb;
   assign O_WR_PAGE = s_q.wr_page;
   assign O_WR_ADDR = s_q.wr_addr;
   assign O_WR_DATA = s_q.wr_data;
   assign O_PAGE = s_q.page;
   assign O_IRQ_MASK = s_q.mask;
endmodule

// ==== include/led_i2c_pkg.sv ====
package led_i2c_pkg;
   // ----------------------------------------
   // target address
   // ----------------------------------------
   localparam logic [2:0] ADDR_HIGH = 3'h5;
   localparam logic [3:0] STRAP_BITS_GND = 4'h0;
   localparam logic [3:0] STRAP_BITS_VCC = 4'hF;
   localparam logic [3:0] STRAP_BITS_SCL = 4'h5;
   localparam logic [3:0] STRAP_BITS_SDA = 4'hA;
   typedef enum logic [1:0] {
      TIE_GND = 2'h0,
      TIE_VCC = 2'h1,
      TIE_SCL = 2'h2,
      TIE_SDA = 2'h3
   } strap_e;
   // ----------------------------------------
   // device register map
   // ----------------------------------------
   localparam logic [7:0] REG_IRQ_MASK = 8'hF0;
   localparam logic [7:0] REG_IRQ_STATUS = 8'hF1;
   localparam logic [7:0] REG_PAGE_SELECT = 8'hFD;
   localparam logic [7:0] REG_UNLOCK_KEY = 8'hFE;
   localparam logic [7:0] UNLOCK_VALUE = 8'hC5;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] LED_CONTROL_PAGE = 8'h00;
   localparam logic [7:0] PWM_PAGE = 8'h01;
   localparam logic [7:0] BREATHING_PAGE = 8'h02;
   localparam logic [7:0] FUNCTION_PAGE = 8'h03;
   localparam logic [7:0] STAT_A_LO = 8'h18;
   localparam logic [7:0] STAT_A_HI = 8'h28;
   localparam logic [7:0] STAT_B_LO = 8'h30;
   localparam logic [7:0] STAT_B_HI = 8'h40;
   localparam logic [7:0] FUNC_READ_REG = 8'h11;
   // ----------------------------------------
   // controller registers on the system bus
   // ----------------------------------------
   localparam logic [7:0] CTL_CMD_OFS = 8'h00;
   localparam logic [7:0] CTL_STATUS_OFS = 8'h04;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_OP_LSB = 8;
   localparam int CMD_NACK_BIT = 11;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ACK_BIT = 1;
   localparam int STAT_DATA_LSB = 8;
   localparam logic [2:0] OP_START = 3'h1;
   localparam logic [2:0] OP_WRITE = 3'h2;
   localparam logic [2:0] OP_READ = 3'h3;
   localparam logic [2:0] OP_STOP = 3'h4;
   // ----------------------------------------
   // timing: quarter of a 400 kHz bit period
   // ----------------------------------------
   localparam int SCL_QUARTER_NS = 625;
   localparam int CLOCK_MHZ = 25;
   localparam int QUARTER_CYCLES = (SCL_QUARTER_NS * CLOCK_MHZ + 999) / 1000;
endpackage

// ==== include/i2c_link_if.sv ====
`timescale 1ns/1ps
interface i2c_link_if;
   logic scl;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic sda;
   // open-drain wired-and with pull-up
   assign sda = ~((host_sda_oe & ~host_sda_out) |
                  (dev_sda_oe & ~dev_sda_out));
   modport dev_mp(input scl, input sda, output dev_sda_out,
                  output dev_sda_oe);
   modport host_mp(output scl, input sda, output host_sda_out,
                   output host_sda_oe);
endinterface

// ==== core/led_i2c_master.sv ====
`timescale 1ns/1ps
module led_i2c_master
   import led_i2c_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES
)(
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST,
   // system bus slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // serial link
   i2c_link_if.host_mp LINK
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_START = 4'b0010,
      H_BIT = 4'b0100,
      H_STOP = 4'b1000
   } host_st_e;
   typedef struct packed {
      host_st_e st;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [7:0] qcnt;
      logic [7:0] sh;
      logic ack;
      logic nack;
      logic wr;
      logic scl;
      logic drv;
      logic hw;
      logic rdy;
      logic [31:0] hrdata;
   } host_s;
   localparam host_s HOST_RST = '{st: H_IDLE, ph: 2'h0, bitn: 4'h0,
      qcnt: 8'h00, sh: 8'h00, ack: 1'b0, nack: 1'b0, wr: 1'b0,
      scl: 1'b1, drv: 1'b0, hw: 1'b0, rdy: 1'b1, hrdata: 32'h0};
   host_s s_q;
   host_s s_d;
   logic tick_c;
   logic [2:0] op_c;
   assign tick_c = (s_q.qcnt == 8'(QUARTER - 1));
   assign op_c = I_HWDATA[CMD_OP_LSB +: 3];
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rdy = 1'b1;
      s_d.hw = 1'b0;
      // address phase: any transfer size decodes; reads answer now
      if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
         s_d.hw = I_HWRITE && I_HADDR[7:0] == CTL_CMD_OFS;
         s_d.hrdata = 32'h0;
         if (!I_HWRITE && I_HADDR[7:0] == CTL_STATUS_OFS) begin
            s_d.hrdata[STAT_BUSY_BIT] = (s_q.st != H_IDLE);
            s_d.hrdata[STAT_ACK_BIT] = s_q.ack;
            s_d.hrdata[STAT_DATA_LSB +: 8] = s_q.sh;
         end
      end
      // data phase of a command write; ignored while busy
      if (s_q.hw && s_q.st == H_IDLE) begin
         s_d.ph = 2'h0;
         s_d.bitn = 4'h0;
         s_d.qcnt = 8'h00;
         s_d.nack = I_HWDATA[CMD_NACK_BIT];
         case (op_c)
            OP_START: s_d.st = H_START;
            OP_WRITE: begin
               s_d.st = H_BIT;
               s_d.wr = 1'b1;
               s_d.sh = I_HWDATA[CMD_DATA_LSB +: 8];
            end
            OP_READ: begin
               s_d.st = H_BIT;
               s_d.wr = 1'b0;
               s_d.sh = 8'h00;
            end
            OP_STOP: s_d.st = H_STOP;
            default: ;
         endcase
      end else if (s_q.st != H_IDLE) begin
         s_d.qcnt = tick_c ? 8'h00 : s_q.qcnt + 8'h01;
         if (tick_c) begin
            s_d.ph = s_q.ph + 2'h1;
            case (s_q.st)
               H_START: begin
                  case (s_q.ph)
                     2'h0: begin
                        s_d.scl = 1'b0;
                        s_d.drv = 1'b0;
                     end
                     2'h1: s_d.scl = 1'b1;
                     2'h2: s_d.drv = 1'b1;
                     default: begin
                        s_d.scl = 1'b0;
                        s_d.st = H_IDLE;
                     end
                  endcase
               end
               H_BIT: begin
                  case (s_q.ph)
                     2'h0: begin
                        s_d.scl = 1'b0;
                        if (s_q.bitn == 4'h8) begin
                           s_d.drv = s_q.wr ? 1'b0 : ~s_q.nack;
                        end else begin
                           s_d.drv = s_q.wr & ~s_q.sh[7];
                        end
                     end
                     2'h1: s_d.scl = 1'b1;
                     2'h2: begin
                        // sample mid-high; a write reads back its own bit
                        if (s_q.bitn == 4'h8) begin
                           s_d.ack = ~LINK.sda;
                        end else begin
                           s_d.sh = {s_q.sh[6:0], LINK.sda};
                        end
                     end
                     default: begin
                        s_d.scl = 1'b0;
                        s_d.bitn = s_q.bitn + 4'h1;
                        if (s_q.bitn == 4'h8) begin
                           s_d.drv = 1'b0;
                           s_d.st = (s_q.wr && !s_q.ack) ? H_STOP
                                                          : H_IDLE;
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  case (s_q.ph)
                     2'h0: begin
                        s_d.scl = 1'b0;
                        s_d.drv = 1'b1;
                     end
                     2'h1: s_d.scl = 1'b1;
                     2'h2: s_d.drv = 1'b0;
                     default: s_d.st = H_IDLE;
                  endcase
               end
               default: s_d.st = H_IDLE;
            endcase
         end
      end
   end
   // ----------------------------------------
   // registers and outputs
   // ----------------------------------------
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         s_q <= HOST_RST;
      end else begin
         s_q <= s_d;
      end
   end
   assign LINK.scl = s_q.scl;
   assign LINK.host_sda_out = 1'b0;
   assign LINK.host_sda_oe = s_q.drv;
   assign O_HRDATA = s_q.hrdata;
   assign O_HREADYOUT = s_q.rdy;
   assign O_HRESP = 1'b0;
endmodule

// ==== tb/i2c_link_asserts.sv ====
`timescale 1ns/1ps
module i2c_link_asserts (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST,
   // link wires
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_out,
   input wire logic host_sda_oe,
   input wire logic dev_sda_out,
   input wire logic dev_sda_oe
);
   // ----------------------------------------
   // frame tracking
   // ----------------------------------------
   logic scl_q;
   logic sda_q;
   logic frame_q;
   logic start;
   logic stop;
   // both conditions need the clock high in two samples, as the target
   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   // a stop closes the frame so stray drive after it is caught
   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         frame_q <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         frame_q <= start ? 1'b1 : (stop ? 1'b0 : frame_q);
      end
   end
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_dev_drive_low:
      assert property (dev_sda_oe |-> !dev_sda_out)
      else $error("device drives sda high");
   a_dev_oe_hold:
      assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
      else $error("device let go of sda too soon");
   a_dev_edge_low:
      assert property ($changed(dev_sda_oe) |-> !scl && !scl_q)
      else $error("device moved sda while scl high");
   a_no_clash:
      assert property (dev_sda_oe && scl |-> !host_sda_oe)
      else $error("both ends pull sda in a high pulse");
   a_quiet_idle:
      assert property (!frame_q |-> !dev_sda_oe)
      else $error("device drives sda outside a frame");
   a_ack_release:
      assert property ($rose(dev_sda_oe) |-> ##[1:300] !dev_sda_oe)
      else $error("device never released sda");
   a_start_hold:
      assert property (start |-> scl[*2])
      else $error("scl fell right after start");
   a_stop_free:
      assert property (stop |-> sda[*3] ##0 !dev_sda_oe)
      else $error("sda not free after stop");
   a_host_edge:
      assert property ($changed(host_sda_oe) && scl && scl_q
         |-> start || stop)
      else $error("host moved sda inside a data bit");
   // main scenarios
   cover property ($rose(dev_sda_oe));
   cover property (start && frame_q);
   cover property (stop);
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import led_i2c_pkg::*;
   localparam int LIMIT = 60000;
   logic clk, rst, hsel, hwrite, hready, hresp, wr_stb;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] irq_st, rd_addr, rd_data, wr_page, wr_addr, wr_data;
   logic [7:0] page, mask;
   logic [6:0] dev;
   logic [23:0] stb_q[$];
   strap_e strap;
   int fail_count, checked, cycles;
   // ----------------------------------------
   // design, link and checker
   // ----------------------------------------
   i2c_link_if i2c_link_if_i ();
   led_i2c_master #(.QUARTER(4)) led_i2c_master_i (.I_CLOCK(clk),
      .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
      .O_HRESP(hresp), .LINK(i2c_link_if_i));
   led_i2c_target led_i2c_target_i (.I_CLOCK(clk), .I_RST(rst),
      .LINK(i2c_link_if_i), .I_STRAP(strap), .I_IRQ_STATUS(irq_st),
      .O_RD_ADDR(rd_addr), .I_RD_DATA(rd_data), .O_WR_STB(wr_stb),
      .O_WR_PAGE(wr_page), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data),
      .O_PAGE(page), .O_IRQ_MASK(mask));
   i2c_link_asserts i2c_link_asserts_i (.I_CLOCK(clk), .I_RST(rst),
      .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
      .host_sda_out(i2c_link_if_i.host_sda_out),
      .host_sda_oe(i2c_link_if_i.host_sda_oe),
      .dev_sda_out(i2c_link_if_i.dev_sda_out),
      .dev_sda_oe(i2c_link_if_i.dev_sda_oe));
   // page registers answer with a pattern derived from the pointer
   assign rd_data = rd_addr ^ 8'hA5;
   always #20 clk = ~clk;
   // record every page write strobe; fields hold until the next one
   always @(posedge clk) begin
      if (wr_stb === 1'b1)
         stb_q.push_back({wr_page, wr_addr, wr_data});
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         close_out();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // one single word transfer; the waits end on hready, not a count
   task automatic ahb(input logic wr, input logic [7:0] ofs,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, ofs};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // busy shows two cycles after the command; poll until it drops
   task automatic op(input logic [2:0] code, input logic [7:0] b,
         input logic nack, output logic [31:0] s);
      ahb(1'b1, CTL_CMD_OFS, {20'h0, nack, code, b}, s);
      repeat (2) @(posedge clk);
      do ahb(1'b0, CTL_STATUS_OFS, 32'h0, s);
      while (s[STAT_BUSY_BIT] !== 1'b0);
   endtask
   // a missed address ack makes the controller stop on its own
   task automatic wframe(input logic [6:0] a, input logic [7:0] r,
         input logic [7:0] d[$], output logic ack);
      logic [31:0] s;
      op(OP_START, 8'h00, 1'b0, s);
      op(OP_WRITE, {a, 1'b0}, 1'b0, s);
      ack = s[STAT_ACK_BIT];
      if (ack === 1'b1) begin
         op(OP_WRITE, r, 1'b0, s);
         check("reg ack", s[STAT_ACK_BIT], 1'b1);
         foreach (d[i]) begin
            op(OP_WRITE, d[i], 1'b0, s);
            check("data ack", s[STAT_ACK_BIT], 1'b1);
         end
         op(OP_STOP, 8'h00, 1'b0, s);
      end
   endtask
   task automatic rframe(input logic [6:0] a, input logic [7:0] r,
         input int n, output logic [7:0] q[$]);
      logic [31:0] s;
      q = {};
      op(OP_START, 8'h00, 1'b0, s);
      op(OP_WRITE, {a, 1'b0}, 1'b0, s);
      op(OP_WRITE, r, 1'b0, s);
      op(OP_START, 8'h00, 1'b0, s);
      op(OP_WRITE, {a, 1'b1}, 1'b0, s);
      check("read addr ack", s[STAT_ACK_BIT], 1'b1);
      for (int i = 0; i < n; i++) begin
         op(OP_READ, 8'h00, i == n - 1, s);
         q.push_back(s[15:8]);
      end
      op(OP_STOP, 8'h00, 1'b0, s);
   endtask
   task automatic sel_page(input logic [7:0] p);
      logic ack;
      wframe(dev, REG_UNLOCK_KEY, {UNLOCK_VALUE}, ack);
      wframe(dev, REG_PAGE_SELECT, {p}, ack);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [7:0] q[$];
      check("page", page, PAGE_RESET);
      check("mask", mask, MASK_RESET);
      rframe(dev, REG_UNLOCK_KEY, 1, q);
      check("key", q[0], KEY_RESET);
      rframe(dev, REG_IRQ_MASK, 1, q);
      check("mask read", q[0], 8'h00);
      irq_st <= 8'h3C;
      rframe(dev, REG_IRQ_STATUS, 1, q);
      check("irq status", q[0], 8'h3C);
      $display("test reset done");
   endtask
   // each strap level, a foreign low nibble and foreign high bits
   task automatic t_strap();
      logic [3:0] lo[4] = '{STRAP_BITS_GND, STRAP_BITS_VCC,
         STRAP_BITS_SCL, STRAP_BITS_SDA};
      logic ack;
      for (int i = 0; i < 4; i++) begin
         strap <= strap_e'(i);
         do_reset();
         dev = {ADDR_HIGH, lo[i]};
         wframe(dev, REG_IRQ_MASK, {8'h00}, ack);
         check("own ack", ack, 1'b1);
         wframe({ADDR_HIGH, ~lo[i]}, REG_IRQ_MASK, {8'h77}, ack);
         check("foreign ack", ack, 1'b0);
         wframe({3'h3, lo[i]}, REG_IRQ_MASK, {8'h77}, ack);
         check("high bits ack", ack, 1'b0);
         check("mask kept", mask, MASK_RESET);
      end
      $display("test strap done");
   endtask
   task automatic t_page();
      logic [7:0] pg[4] = '{PWM_PAGE, BREATHING_PAGE, FUNCTION_PAGE,
         LED_CONTROL_PAGE};
      logic [7:0] q[$];
      logic ack;
      wframe(dev, REG_PAGE_SELECT, {PWM_PAGE}, ack);
      check("locked page", page, LED_CONTROL_PAGE);
      for (int i = 0; i < 4; i++) begin
         wframe(dev, REG_UNLOCK_KEY, {UNLOCK_VALUE}, ack);
         rframe(dev, REG_UNLOCK_KEY, 1, q);
         check("key set", q[0], UNLOCK_VALUE);
         wframe(dev, REG_PAGE_SELECT, {pg[i]}, ack);
         check("page", page, pg[i]);
         rframe(dev, REG_UNLOCK_KEY, 1, q);
         check("key cleared", q[0], KEY_RESET);
         wframe(dev, REG_PAGE_SELECT, {pg[i] ^ 8'h01}, ack);
         check("one change", page, pg[i]);
      end
      // reserved codes are kept as written
      sel_page(8'h07);
      check("reserved page", page, 8'h07);
      check("no strobes", stb_q.size(), 0);
      $display("test page done");
   endtask
   task automatic t_autoinc();
      logic [7:0] d[3] = '{8'hA1, 8'hB2, 8'hC3};
      logic ack;
      logic [23:0] want;
      sel_page(BREATHING_PAGE);
      stb_q.delete();
      wframe(dev, 8'h20, {d[0], d[1], d[2]}, ack);
      // the second byte lands on the status register and must vanish
      wframe(dev, REG_IRQ_MASK, {8'h5A, 8'h11}, ack);
      check("mask", mask, 8'h5A);
      check("strobes", stb_q.size(), 3);
      foreach (d[i]) begin
         want = {BREATHING_PAGE, 8'h20 + 8'(i), d[i]};
         check("strobe", stb_q[i], want);
      end
      $display("test autoinc done");
   endtask
   task automatic t_read();
      logic [7:0] q[$];
      sel_page(LED_CONTROL_PAGE);
      rframe(dev, STAT_A_HI, 2, q);
      check("range end", q[0], STAT_A_HI ^ 8'hA5);
      check("gap", q[1], 8'h00);
      rframe(dev, STAT_B_LO, 1, q);
      check("range b", q[0], STAT_B_LO ^ 8'hA5);
      sel_page(FUNCTION_PAGE);
      rframe(dev, FUNC_READ_REG, 1, q);
      check("page3 reg", q[0], FUNC_READ_REG ^ 8'hA5);
      rframe(dev, STAT_A_LO, 1, q);
      check("wrong page", q[0], 8'h00);
      $display("test read done");
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      strap = TIE_GND;
      irq_st = 8'h00;
      fail_count = 0;
      checked = 0;
      cycles = 0;
      dev = {ADDR_HIGH, STRAP_BITS_GND};
      do_reset();
      t_reset();
      t_strap();
      t_page();
      t_autoinc();
      t_read();
      close_out();
   end
endmodule
